// file: common/omc_pkg.sv
package omc_pkg;

    // ****************************************************************
    // Register offsets (byte addresses, one aligned word each)
    // ****************************************************************
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL0 = 8'h00;
    localparam logic [7:0] OFS_FLAGS = 8'h04;
    localparam logic [7:0] OFS_EFER = 8'h08;
    localparam logic [7:0] OFS_PBASE_LO = 8'h0c;
    localparam logic [7:0] OFS_PBASE_HI = 8'h10;
    localparam logic [7:0] OFS_CODESEG = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_TASKPRI = 8'h1c;
    localparam logic [7:0] OFS_EVENT = 8'h20;
    localparam logic [7:0] OFS_FLAGS_STAGE = 8'h24;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int unsigned CTRL0_PE_BIT = 0;
    localparam int unsigned CTRL0_PG_BIT = 31;
    localparam int unsigned FLAGS_VM_BIT = 17;
    localparam int unsigned EFER_LME_BIT = 8;
    localparam int unsigned EFER_LMA_BIT = 10;
    localparam int unsigned CODESEG_LONG_BIT = 0;
    localparam int unsigned EVENT_TASKSW_BIT = 0;
    localparam int unsigned EVENT_RESUME_BIT = 1;
    localparam int unsigned STATUS_SMM_BIT = 3;
    localparam int unsigned STATUS_LMA_BIT = 4;
    localparam int unsigned STATUS_PEND_BIT = 5;

    // ****************************************************************
    // Reset values and widths
    // ****************************************************************
    localparam logic [31:0] CTRL0_RST = 32'h0000_0000;
    localparam logic [31:0] FLAGS_RST = 32'h0000_0002;
    localparam logic [63:0] PBASE_RST = 64'h0000_0000_0000_0000;
    localparam logic [3:0] TASKPRI_RST = 4'h0;
    localparam int unsigned TASKPRI_W = 4;
    localparam int unsigned PHYS_W = 52;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        MODE_REAL, MODE_PROT, MODE_VIRT, MODE_LONG64, MODE_COMPAT, MODE_SMM
    } omc_mode_t;

    typedef enum logic [1:0] {WALK_FLAT, WALK_TWO, WALK_FOUR} omc_walk_t;

    typedef struct packed {
        omc_walk_t walk;
        logic [63:0] root;
        logic [9:0] idx3;
        logic [9:0] idx2;
        logic [9:0] idx1;
        logic [9:0] idx0;
        logic [11:0] offset;
        logic [63:0] phys;
    } omc_xlate_t;

    typedef struct packed {
        logic desc_tables_64;
        logic ctrl_regs_64;
        logic flags_64;
        logic task_pri_visible;
        logic debug_regs_64;
        logic bp_match_64;
        logic linear_64;
        logic phys_wide;
    } omc_width_t;

    typedef struct packed {
        logic [31:0] cr0;
        logic [31:0] flags;
        logic long_mode_enable_bit;
        logic cs_long;
        logic [63:0] pbase;
        logic long_mode_active_bit;
        omc_mode_t mode;
    } omc_ctx_t;

endpackage

// file: verilog/omc_core.sv
// Operation
// (RULE1) Any reset puts the block in real-address mode.
// (RULE2) Protection-enable flag selects real-address versus protected operation.
// (RULE3) In protected operation, virtual-mode flag selects legacy virtual mode.
// (RULE4) Task switch or handler return normally moves between these modes.
// (RULE5) Long-mode-active bit 10 of the feature register reports long mode.
// (RULE6) In long mode, code-segment long bit picks 64-bit or compatibility.
// (RULE7) Long mode entered from protected only with paging and enable bit 8.
// (RULE8) A management interrupt from any other mode enters management mode.
// (RULE9) The resume instruction returns to exactly the interrupted mode.
// (RULE10) Management entry saves context; resume restores it; separate space.
// (RULE11) Platform logic requests management mode on the dedicated pin.
// (RULE12) Without paging, linear address passes unchanged as physical.
// (RULE13) Legacy paging splits address into directory, table and page offset.
// (RULE14) Directory base comes from the page-base control register.
// (RULE15) Both long sub-modes walk four levels of tables.
// (RULE16) In long mode, the top-level map base comes from page base.
// (RULE17) Long mode widens table, task and control registers; exposes TASK_PRIORITY_REGISTER.
// (RULE18) Long mode widens the system flags register to 64 bits.
// (RULE19) Debug registers 64-bit in 64 sub-mode; breakpoint match both.
// (RULE20) 64-bit sub-mode gives 64-bit linear and wide physical addresses.
// (RULE21) Virtual-mode flag bit 17 set enables virtual mode; clear leaves.
// (RULE22) In long mode, attempts to set the virtual-mode flag are ignored.
// (RULE23) Mode is one encoded value; management mode overrides all others.
//
// Local design decisions: the register offsets and the Avalon-MM register port.
module omc_core (
    // Clock and reset
    input logic SYS_CLK,
    input logic NRST,
    // Avalon-MM register slave
    input logic [omc_pkg::ADDR_W-1:0] AVS_ADDRESS,
    input logic AVS_READ,
    input logic AVS_WRITE,
    input logic [31:0] AVS_WRITEDATA,
    input logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // Platform management request
    input logic MANAGEMENT_INTERRUPT_PIN_N,
    // Linear address to translate
    input logic LIN_VALID,
    input logic [63:0] LIN_ADDR,
    // Translation result
    output logic XLATE_VALID,
    output omc_pkg::omc_xlate_t XLATE,
    // Mode indication
    output omc_pkg::omc_mode_t MODE,
    output logic SMM_ACTIVE,
    output logic LONG_MODE_ACTIVE,
    output omc_pkg::omc_width_t WIDTHS,
    output logic [omc_pkg::TASKPRI_W-1:0] TASK_PRIORITY
);
    import omc_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [31:0] cr0_r;
    logic [31:0] flags_r;
    logic [31:0] stage_r;
    logic lme_r;
    logic [63:0] pbase_r;
    logic cs_long_r;
    logic [TASKPRI_W-1:0] tpr_r;
    logic lma_r;
    logic lma_nxt;
    logic smm_r;
    logic smi_prev_r;
    logic smi_pend_r;
    omc_ctx_t ctx_r;
    omc_mode_t mode_r;
    omc_mode_t mode_nxt;
    omc_width_t widths_r;
    omc_xlate_t xl_r;
    omc_xlate_t xl_nxt;
    logic xl_valid_r;
    logic ack_r;
    logic [31:0] rdata_r;
    logic [31:0] rd_nxt;
    logic bus_req;
    logic wr_fire;
    logic [7:0] sel;
    logic smi_req;
    logic smi_any;
    logic enter;
    logic do_resume;
    logic do_tasksw;
    logic pe;
    logic pg;
    logic vm;
    logic [31:0] wmerge;
    logic [63:0] lin_eff;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[8*i +: 8] = data[8*i +: 8];
            end
        end
        return res;
    endfunction

    assign pe = cr0_r[CTRL0_PE_BIT];
    assign pg = cr0_r[CTRL0_PG_BIT];
    assign vm = flags_r[FLAGS_VM_BIT];

    // ****************************************************************
    // Bus slave: one wait state, writes commit when waitrequest is low
    // ****************************************************************
    assign bus_req = AVS_READ | AVS_WRITE;
    assign AVS_WAITREQUEST = bus_req & ~ack_r;
    assign wr_fire = AVS_WRITE & ack_r;
    assign sel = {AVS_ADDRESS[7:2], 2'b00};
    assign AVS_READDATA = rdata_r;
    assign do_resume = wr_fire && sel == OFS_EVENT
                       && AVS_BYTEENABLE[0]
                       && AVS_WRITEDATA[EVENT_RESUME_BIT] && smm_r;
    assign do_tasksw = wr_fire && sel == OFS_EVENT
                       && AVS_BYTEENABLE[0]
                       && AVS_WRITEDATA[EVENT_TASKSW_BIT];

    always_comb begin
        rd_nxt = UNMAPPED_DATA;
        case (sel)
            OFS_CTRL0: rd_nxt = cr0_r;
            OFS_FLAGS: rd_nxt = flags_r;
            OFS_FLAGS_STAGE: rd_nxt = stage_r;
            OFS_EFER: begin
                rd_nxt[EFER_LME_BIT] = lme_r;
                rd_nxt[EFER_LMA_BIT] = lma_r; // see (RULE5)
            end
            OFS_PBASE_LO: rd_nxt = pbase_r[31:0];
            OFS_PBASE_HI: rd_nxt = pbase_r[63:32];
            OFS_CODESEG: rd_nxt[CODESEG_LONG_BIT] = cs_long_r;
            OFS_STATUS: begin
                rd_nxt[2:0] = mode_r;
                rd_nxt[STATUS_SMM_BIT] = smm_r;
                rd_nxt[STATUS_LMA_BIT] = lma_r;
                rd_nxt[STATUS_PEND_BIT] = smi_pend_r;
            end
            OFS_TASKPRI: begin
                if (lma_r) begin
                    rd_nxt[TASKPRI_W-1:0] = tpr_r; // see (RULE17)
                end
            end
            default: rd_nxt = UNMAPPED_DATA;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r <= bus_req & ~ack_r;
            if (AVS_READ && !ack_r) begin
                rdata_r <= rd_nxt;
            end
        end
    end

    // ****************************************************************
    // Architectural registers, all but the staged flag image and the task priority restored on resume
    // ****************************************************************
    always_comb begin
        wmerge = merge(flags_r, AVS_WRITEDATA, AVS_BYTEENABLE);
        // Long mode may turn on at the same edge as this write, so the
        // virtual flag is also held off while activation is under way.
        if (lma_r || lma_nxt) begin
            wmerge[FLAGS_VM_BIT] = 1'b0; // see (RULE22)
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            cr0_r <= CTRL0_RST;
            flags_r <= FLAGS_RST;
            stage_r <= FLAGS_RST;
            lme_r <= 1'b0;
            pbase_r <= PBASE_RST;
            cs_long_r <= 1'b0;
        end else if (do_resume) begin
            cr0_r <= ctx_r.cr0; // see (RULE10)
            flags_r <= ctx_r.flags;
            lme_r <= ctx_r.long_mode_enable_bit;
            pbase_r <= ctx_r.pbase;
            cs_long_r <= ctx_r.cs_long;
        end else if (do_tasksw) begin
            // Unless long mode is active or turning on, a task switch or handler return loads the virtual-mode bit from the staged flag image.
            if (!lma_r && !lma_nxt) begin
                flags_r[FLAGS_VM_BIT] <= stage_r[FLAGS_VM_BIT]; // see (RULE4)
            end
        end else if (wr_fire) begin
            case (sel)
                OFS_CTRL0: cr0_r <= merge(cr0_r, AVS_WRITEDATA,
                                          AVS_BYTEENABLE);
                OFS_FLAGS: flags_r <= wmerge; // see (RULE21)
                OFS_FLAGS_STAGE: stage_r <= merge(stage_r, AVS_WRITEDATA,
                                                  AVS_BYTEENABLE);
                OFS_EFER: begin
                    if (AVS_BYTEENABLE[1]) begin
                        lme_r <= AVS_WRITEDATA[EFER_LME_BIT];
                    end
                end
                OFS_PBASE_LO: pbase_r[31:0] <= merge(pbase_r[31:0],
                    AVS_WRITEDATA, AVS_BYTEENABLE);
                OFS_PBASE_HI: pbase_r[63:32] <= merge(pbase_r[63:32],
                    AVS_WRITEDATA, AVS_BYTEENABLE);
                OFS_CODESEG: begin
                    if (AVS_BYTEENABLE[0]) begin
                        cs_long_r <= AVS_WRITEDATA[CODESEG_LONG_BIT];
                    end
                end
                default: ;
            endcase
        end
    end

    // The priority register is only reachable while long mode is active.
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            tpr_r <= TASKPRI_RST;
        end else if (wr_fire && sel == OFS_TASKPRI && lma_r
                     && AVS_BYTEENABLE[0]) begin
            tpr_r <= AVS_WRITEDATA[TASKPRI_W-1:0]; // see (RULE17)
        end
    end
    assign TASK_PRIORITY = tpr_r;

    // ****************************************************************
    // Long mode activation
    // ****************************************************************
    // Entry is only from plain protected mode, never from virtual mode.
    assign lma_nxt = pe & pg & lme_r & (lma_r | ~vm); // see (RULE7)

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            lma_r <= 1'b0;
        end else if (do_resume) begin
            lma_r <= ctx_r.long_mode_active_bit;
        end else begin
            lma_r <= lma_nxt;
        end
    end
    assign LONG_MODE_ACTIVE = lma_r; // see (RULE5)

    // ****************************************************************
    // Management mode entry and exit
    // ****************************************************************
    // A request seen while already in management mode is held and taken
    // right after resume; several such requests merge into one entry.
    assign smi_req = smi_prev_r & ~MANAGEMENT_INTERRUPT_PIN_N;
    assign smi_any = smi_pend_r | smi_req;
    assign enter = smi_any & ~smm_r; // see (RULE8)

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            smi_prev_r <= 1'b1;
            smi_pend_r <= 1'b0;
            smm_r <= 1'b0;
        end else begin
            smi_prev_r <= MANAGEMENT_INTERRUPT_PIN_N;
            smi_pend_r <= smi_any & ~enter;
            if (enter) begin
                smm_r <= 1'b1;
            end else if (do_resume) begin
                smm_r <= 1'b0; // see (RULE9)
            end
        end
    end
    assign SMM_ACTIVE = smm_r;

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            ctx_r <= '0;
        end else if (enter) begin
            ctx_r.cr0 <= cr0_r; // see (RULE10)
            ctx_r.flags <= flags_r;
            ctx_r.long_mode_enable_bit <= lme_r;
            ctx_r.cs_long <= cs_long_r;
            ctx_r.pbase <= pbase_r;
            ctx_r.long_mode_active_bit <= lma_r;
            ctx_r.mode <= mode_nxt;
        end
    end

    // ****************************************************************
    // Mode encoding and register widths
    // ****************************************************************
    always_comb begin
        if (smm_r) begin
            mode_nxt = MODE_SMM; // see (RULE23)
        end else if (!pe) begin
            mode_nxt = MODE_REAL; // see (RULE2)
        end else if (lma_r) begin
            mode_nxt = cs_long_r ? MODE_LONG64 : MODE_COMPAT; // see (RULE6)
        end else if (vm) begin
            mode_nxt = MODE_VIRT; // see (RULE3)
        end else begin
            mode_nxt = MODE_PROT;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            mode_r <= MODE_REAL; // see (RULE1)
            widths_r <= '0;
        end else begin
            mode_r <= mode_nxt;
            widths_r.desc_tables_64 <= mode_nxt == MODE_LONG64
                                       || mode_nxt == MODE_COMPAT;
            widths_r.ctrl_regs_64 <= mode_nxt == MODE_LONG64
                                     || mode_nxt == MODE_COMPAT;
            widths_r.flags_64 <= mode_nxt == MODE_LONG64
                                 || mode_nxt == MODE_COMPAT; // see (RULE18)
            widths_r.task_pri_visible <= mode_nxt == MODE_LONG64
                                         || mode_nxt == MODE_COMPAT;
            widths_r.debug_regs_64 <= mode_nxt == MODE_LONG64; // see (RULE19)
            widths_r.bp_match_64 <= mode_nxt == MODE_LONG64
                                    || mode_nxt == MODE_COMPAT;
            widths_r.linear_64 <= mode_nxt == MODE_LONG64; // see (RULE20)
            widths_r.phys_wide <= mode_nxt == MODE_LONG64;
        end
    end
    assign MODE = mode_r;
    assign WIDTHS = widths_r; // see (RULE17)

    // ****************************************************************
    // Address translation selection
    // ****************************************************************
    // Only the 64-bit sub-mode sees the full linear address; all other
    // modes see the low 32 bits, so stray high bits cannot leak through.
    assign lin_eff = (pe && pg && lma_r && cs_long_r && !smm_r) ? LIN_ADDR
                     : {32'h0000_0000, LIN_ADDR[31:0]}; // see (RULE20)

    always_comb begin
        xl_nxt = '0;
        xl_nxt.offset = lin_eff[11:0];
        if (smm_r || !pe || !pg) begin
            xl_nxt.walk = WALK_FLAT;
            xl_nxt.phys = lin_eff; // see (RULE12)
        end else if (lma_r) begin
            xl_nxt.walk = WALK_FOUR; // see (RULE15)
            xl_nxt.root = {pbase_r[63:12], 12'h000}; // see (RULE16)
            xl_nxt.idx3 = {1'b0, lin_eff[47:39]};
            xl_nxt.idx2 = {1'b0, lin_eff[38:30]};
            xl_nxt.idx1 = {1'b0, lin_eff[29:21]};
            xl_nxt.idx0 = {1'b0, lin_eff[20:12]};
        end else begin
            xl_nxt.walk = WALK_TWO; // see (RULE13)
            xl_nxt.root = {pbase_r[63:12], 12'h000}; // see (RULE14)
            xl_nxt.idx1 = lin_eff[31:22];
            xl_nxt.idx0 = lin_eff[21:12];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            xl_valid_r <= 1'b0;
            xl_r <= '0;
        end else begin
            xl_valid_r <= LIN_VALID;
            if (LIN_VALID) begin
                xl_r <= xl_nxt;
            end
        end
    end
    assign XLATE_VALID = xl_valid_r;
    assign XLATE = xl_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    reset_real_a: assert property (@(posedge SYS_CLK) // see (RULE1)
        !$past(NRST) |-> MODE == MODE_REAL)
        else $error("Mode is not real after reset.");

    pe_select_a: assert property (@(posedge SYS_CLK) // see (RULE2)
        disable iff (!NRST)
        !smm_r && !pe |=> MODE == MODE_REAL)
        else $error("Clear protection flag did not give real mode.");

    virt_select_a: assert property (@(posedge SYS_CLK) // see (RULE3)
        disable iff (!NRST)
        !smm_r && pe && !lma_r && vm |=> MODE == MODE_VIRT)
        else $error("Virtual flag did not give legacy virtual mode.");

    long_entry_a: assert property (@(posedge SYS_CLK) // see (RULE7)
        disable iff (!NRST)
        $rose(lma_r) && !$past(do_resume) |->
            $past(pe && pg && lme_r && !vm))
        else $error("Long mode became active without its conditions.");

    sub_mode_a: assert property (@(posedge SYS_CLK) // see (RULE6)
        disable iff (!NRST)
        !smm_r && pe && lma_r |=>
            MODE == ($past(cs_long_r) ? MODE_LONG64 : MODE_COMPAT))
        else $error("Long sub-mode does not follow the code segment.");

    lma_report_a: assert property (@(posedge SYS_CLK) // see (RULE5)
        disable iff (!NRST)
        AVS_READ && !ack_r && sel == OFS_EFER |=>
            AVS_READDATA[EFER_LMA_BIT] == $past(lma_r))
        else $error("Feature register read does not show long state.");

    smm_enter_a: assert property (@(posedge SYS_CLK) // see (RULE8)
        disable iff (!NRST)
        enter |=> smm_r ##1 MODE == MODE_SMM)
        else $error("Management request did not enter management mode.");

    resume_mode_a: assert property (@(posedge SYS_CLK) // see (RULE9)
        disable iff (!NRST)
        do_resume |=> !smm_r ##1 MODE == $past(ctx_r.mode, 2))
        else $error("Resume did not return to the interrupted mode.");

    ctx_restore_a: assert property (@(posedge SYS_CLK) // see (RULE10)
        disable iff (!NRST)
        do_resume |=> cr0_r == $past(ctx_r.cr0)
            && pbase_r == $past(ctx_r.pbase))
        else $error("Context was not restored on resume.");

    flat_pass_a: assert property (@(posedge SYS_CLK) // see (RULE12)
        disable iff (!NRST)
        LIN_VALID && !smm_r && !pe |=> XLATE_VALID
            && XLATE.walk == WALK_FLAT
            && XLATE.phys == {32'h0000_0000, $past(LIN_ADDR[31:0])})
        else $error("Flat translation altered the address.");

    four_level_a: assert property (@(posedge SYS_CLK) // see (RULE15)
        disable iff (!NRST)
        LIN_VALID && !smm_r && pe && pg && lma_r && cs_long_r |=>
            XLATE.walk == WALK_FOUR
            && XLATE.idx3 == {1'b0, $past(LIN_ADDR[47:39])})
        else $error("Long mode did not select a four-level walk.");

    vm_blocked_a: assert property (@(posedge SYS_CLK) // see (RULE22)
        disable iff (!NRST)
        lma_r && !do_resume |=> !vm)
        else $error("Virtual flag set while long mode is active.");

    debug_width_a: assert property (@(posedge SYS_CLK) // see (RULE19)
        disable iff (!NRST)
        WIDTHS.debug_regs_64 == (MODE == MODE_LONG64)
            && WIDTHS.bp_match_64 == (MODE == MODE_LONG64
                                      || MODE == MODE_COMPAT))
        else $error("Debug widths disagree with the mode.");

endmodule

// file: dv/omc_platform.sv
module omc_platform #(
    parameter int unsigned LAG = 0,
    parameter int unsigned HOLD = 2
) (
    // Clock and reset
    input logic clk,
    input logic nrst,
    // Request from the bench
    input logic fire,
    // Pin toward the device, idle high
    output logic pin_n
);
    timeunit 1ns;
    timeprecision 100ps;
    // The lag lets one model stand for a prompt or a slow platform.
    int unsigned cnt;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt <= 0;
            pin_n <= 1'b1;
        end else begin
            if (fire && cnt == 0) begin
                cnt <= LAG + HOLD;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
            pin_n <= !(cnt != 0 && cnt <= HOLD);
        end
    end
endmodule

// file: dv/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import omc_pkg::*;
    logic clk, nrst, rd, wr, lin_valid, pin_n, fire, system_management_mode, long_mode_active_bit, xv, wreq;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, q;
    logic [63:0] lin_addr, a;
    logic [3:0] tpri;
    omc_xlate_t xlate;
    omc_mode_t mode;
    omc_width_t widths;
    int error_cnt, n_checks;
    omc_platform #(.LAG(3), .HOLD(2)) omc_platform_inst (.clk(clk),
        .nrst(nrst), .fire(fire), .pin_n(pin_n));
    omc_core omc_core_inst (.SYS_CLK(clk), .NRST(nrst), .AVS_ADDRESS(addr),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
        .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq),
        .MANAGEMENT_INTERRUPT_PIN_N(pin_n), .LIN_VALID(lin_valid),
        .LIN_ADDR(lin_addr), .XLATE_VALID(xv), .XLATE(xlate), .MODE(mode),
        .SMM_ACTIVE(system_management_mode), .LONG_MODE_ACTIVE(long_mode_active_bit), .WIDTHS(widths),
        .TASK_PRIORITY(tpri));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // Holds the request until waitrequest is sampled low, as the bus asks.
    task automatic bus(input logic w, input logic [7:0] ad,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        addr <= ad;
        wdata <= d;
        wr <= w;
        rd <= !w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        if (wreq !== 1'b0) begin
            error_cnt++;
            complete_run();
        end
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] ad, input logic [31:0] e);
        bus(1'b0, ad, 32'h0);
        chk(q, e);
    endtask
    task automatic waitm(input omc_mode_t m);
        int n;
        for (n = 0; n < 12 && mode !== m; n++) @(posedge clk);
        chk(mode, m);
        if (mode !== m) complete_run();
    endtask
    task automatic xl(input logic [63:0] v);
        @(posedge clk);
        lin_valid <= 1'b1;
        lin_addr <= v;
        @(posedge clk);
        lin_valid <= 1'b0;
        @(posedge clk);
        chk(xv, 1);
    endtask
    initial begin
        {rd, wr, lin_valid, fire, nrst} = 5'h0;
        {addr, wdata, lin_addr} = 0;
        a = 64'h0000_7fed_cba9_8765;
        repeat (3) @(posedge clk);
        chk(mode, MODE_REAL);
        nrst <= 1'b1;
        xl(a);
        chk(xlate.phys, {32'h0, a[31:0]});
        bus(1'b1, OFS_CTRL0, 32'h1);
        waitm(MODE_PROT);
        bus(1'b1, OFS_FLAGS, 32'h0002_0002);
        waitm(MODE_VIRT);
        bus(1'b1, OFS_FLAGS_STAGE, 32'h2);
        bus(1'b1, OFS_EVENT, 32'h1);
        waitm(MODE_PROT);
        bus(1'b1, OFS_PBASE_LO, 32'h0012_3abc);
        bus(1'b1, OFS_CTRL0, 32'h8000_0001);
        xl(a);
        chk(xlate.walk, WALK_TWO);
        chk(xlate.root, 64'h12_3000);
        chk({xlate.idx1, xlate.idx0, xlate.offset}, a[31:0]);
        bus(1'b1, OFS_EFER, 32'h100);
        waitm(MODE_COMPAT);
        rdchk(OFS_EFER, 32'h500);
        chk(widths, 8'hf4);
        bus(1'b1, OFS_CODESEG, 32'h1);
        waitm(MODE_LONG64);
        chk(widths, 8'hff);
        rdchk(OFS_STATUS, 32'h13);
        xl(a);
        chk(xlate.walk, WALK_FOUR);
        chk(xlate.root, 64'h12_3000);
        chk({xlate.idx3, xlate.idx2, xlate.idx1, xlate.idx0},
            {1'b0, a[47:39], 1'b0, a[38:30], 1'b0, a[29:21],
             1'b0, a[20:12]});
        bus(1'b1, OFS_FLAGS, 32'h0002_0002);
        repeat (3) @(posedge clk);
        chk(mode, MODE_LONG64);
        rdchk(OFS_FLAGS, 32'h2);
        bus(1'b1, OFS_TASKPRI, 32'h9);
        @(posedge clk);
        chk(tpri, 4'h9);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        waitm(MODE_SMM);
        chk(system_management_mode, 1);
        xl(a);
        chk(xlate.walk, WALK_FLAT);
        bus(1'b1, OFS_CTRL0, 32'h0);
        bus(1'b1, OFS_EVENT, 32'h2);
        waitm(MODE_LONG64);
        rdchk(OFS_CTRL0, 32'h8000_0001);
        rdchk(8'h3c, 32'h0);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        chk(mode, MODE_REAL);
        nrst <= 1'b1;
        complete_run();
    end
endmodule
